// >>> design/interlock_defines.svh
// constants for the interlock forwarding block
`ifndef INTERLOCK_DEFINES_SVH
`define INTERLOCK_DEFINES_SVH
`define ADDR_LANE_CFG 12'h000
`define ADDR_DRV_CTRL 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_OVR_LEVEL 12'h00C
`define CFG_MODE_LSB 0
`define CFG_STATIC_LVL 2
`define CFG_SRC_LSB 3
`define CFG_BITS 7
`define DRV_ENABLE_BIT 0
`define RESET_CFG 32'h00000000
`define SAFE_LEVEL 1'b0
`endif

// >>> design/interlock_pkg.sv
// types for the interlock forwarding block
package interlock_pkg;
    typedef enum logic [1:0] {
        ModeStatic,
        ModeNand,
        ModeOverride,
        ModeRsvd
    } lane_mode_t;
    typedef enum logic [1:0] {
        RmOff,
        RmM1,
        RmActive,
        RmM7
    } rear_state_t;
endpackage : interlock_pkg

// >>> design/interlock_lane.sv
// one combinational output lane: static, nand or override
`timescale 1ns/10ps
`include "interlock_defines.svh"
module interlock_lane (
    input wire logic [1:0] mode,
    input wire logic staticLevel,
    input wire logic [3:0] srcEnable,
    input wire logic [3:0] srcValid,
    input wire logic overrideLevel,
    output logic laneOut
);
    // active-high valid sources; disabled ones forced true so they drop out
    wire [3:0] gated = srcValid | ~srcEnable; // RULE7
    wire allValid = &gated; // RULE8
    // nor of inverted valids: high (permit) only when all enabled valid
    wire nandOut = ~(|(~gated)); // RULE6
    always_comb begin
        case (interlock_pkg::lane_mode_t'(mode))
            interlock_pkg::ModeStatic: laneOut = staticLevel; // RULE5
            interlock_pkg::ModeNand: laneOut = nandOut; // RULE6
            interlock_pkg::ModeOverride: laneOut = overrideLevel; // RULE9
            default: laneOut = `SAFE_LEVEL;
        endcase
    end
endmodule : interlock_lane

// >>> design/interlock_forwarding_logic.sv
// interlock forwarding to the rear module with apb configuration
`timescale 1ns/10ps
`include "interlock_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Operation
// (RULE1) forward only rx19, tx19, rx20 lanes
// (RULE2) forwarding independent of fpga state
// (RULE3) fpga interlock is fourth source
// (RULE4) each lane picks one of three modes
// (RULE5) static mode drives configured constant level
// (RULE6) nand mode combines selected sources
// (RULE7) per-lane enable per nand source
// (RULE8) permit only when all enabled valid
// (RULE9) override follows fpga level per lane
// (RULE10) driver power off in m1 or m7
// (RULE11) rear outputs off when rear inactive; code gates only rearDriverPowerEnable, rearInterlockOutLane stays live
// (RULE12) safe outputs until configuration written
module interlock_forwarding_logic #(
    parameter int LANES = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic laneCryoOk,
    input wire logic laneA,
    input wire logic laneB,
    input wire logic fpgaInterlock,
    input wire logic [LANES-1:0] fpgaOverride,
    input wire logic [1:0] rearState,
    output logic [LANES-1:0] rearInterlockOutLane,
    output logic rearDriverPowerEnable
);
    //////////////////////////////////////////////////////////////////////////
    // input synchronisers, two flops each
    logic [LANES+5:0] sync1_q;
    logic [LANES+5:0] sync2_q;
    always_ff @(posedge clk) begin
        sync1_q <= {rearState, fpgaOverride, fpgaInterlock, laneCryoOk, laneB, laneA};
        sync2_q <= sync1_q;
    end
    // source order: a(tx19), b(rx20), cryo(rx19), fpga
    wire [3:0] srcValid = {sync2_q[3], sync2_q[2], sync2_q[1], sync2_q[0]}; // RULE1 RULE3
    wire [LANES-1:0] ovrSync = sync2_q[LANES+3:4];
    wire [1:0] rearSync = sync2_q[LANES+5:LANES+4];

    //////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    logic [`CFG_BITS*LANES-1:0] cfg_q;
    logic [LANES-1:0] cfgDone_q;
    logic drvCtrl_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pready_q;
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire [9:0] wordIdx = paddr[11:2];
    wire isLaneCfg = wordIdx < 10'(LANES);
    wire isDrv = paddr == (`ADDR_DRV_CTRL + 12'(LANES*4));
    wire isStat = paddr == (`ADDR_STATUS + 12'(LANES*4));
    wire mapped = isLaneCfg || isDrv || isStat;
    wire wrEn = access && pwrite && mapped;
    logic [LANES-1:0] laneOut;
    wire rearActive = interlock_pkg::rear_state_t'(rearSync) == interlock_pkg::RmActive;

    function automatic logic [31:0] readMux(input logic [9:0] idx, input logic drvSel,
                                           input logic statSel);
        logic [31:0] r;
        r = 32'h00000000;
        if (statSel)
            r = {20'h00000, 2'(rearSync), 2'h0, 4'(LANES'(cfgDone_q)), 4'(LANES'(laneOut))};
        else if (drvSel)
            r = {31'h00000000, drvCtrl_q};
        else if (idx < 10'(LANES))
            r = {25'h0000000, cfg_q[idx*`CFG_BITS +: `CFG_BITS]};
        return r;
    endfunction : readMux

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= '0;
            cfgDone_q <= '0;
            drvCtrl_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            if (wrEn && isLaneCfg) begin
                cfg_q[wordIdx*`CFG_BITS +: `CFG_BITS] <= pwdata[`CFG_BITS-1:0]; // RULE4
                cfgDone_q[wordIdx[1:0]] <= 1'b1; // RULE12
            end
            if (wrEn && isDrv)
                drvCtrl_q <= pwdata[`DRV_ENABLE_BIT];
            if (setup) begin
                prdata_q <= readMux(wordIdx, isDrv, isStat);
                pslverr_q <= !mapped;
            end
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    //////////////////////////////////////////////////////////////////////////
    // lanes: combinational from synchronised inputs, no fpga handshake needed
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gLane
            interlock_lane uLane (
                .mode(cfg_q[g*`CFG_BITS + `CFG_MODE_LSB +: 2]),
                .staticLevel(cfg_q[g*`CFG_BITS + `CFG_STATIC_LVL]),
                .srcEnable(cfg_q[g*`CFG_BITS + `CFG_SRC_LSB +: 4]),
                .srcValid(srcValid),
                .overrideLevel(ovrSync[g]),
                .laneOut(laneOut[g])
            ); // RULE2 RULE4
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // registered outputs; unconfigured lanes held non-permitting
    logic [LANES-1:0] out_q;
    logic drv_q;
    wire allCfg = &cfgDone_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_q <= '0;
            drv_q <= 1'b0;
        end else begin
            out_q <= laneOut & cfgDone_q; // RULE12
            // off unless rear module active: covers m1, m7 and hot plug
            drv_q <= drvCtrl_q && rearActive && allCfg; // RULE10 RULE11
        end
    end
    assign rearInterlockOutLane = out_q;
    assign rearDriverPowerEnable = drv_q;

    //////////////////////////////////////////////////////////////////////////
    // checks
    AST_DRV_OFF_INACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rearActive) |-> !rearDriverPowerEnable) // RULE10
        else $error("driver power on while rear inactive");
    AST_DRV_NEEDS_CFG: assert property (@(posedge clk) disable iff (!rst_n)
        rearDriverPowerEnable |-> $past(allCfg)) // RULE12
        else $error("driver power on before configuration");
    AST_UNCFG_SAFE: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(cfgDone_q[0]) |-> !rearInterlockOutLane[0]) // RULE12
        else $error("unconfigured lane permitting");
    AST_STATIC_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        (cfgDone_q[0] && cfg_q[1:0] == 2'h0) |=> rearInterlockOutLane[0] == $past(cfg_q[2]))
        // RULE5
        else $error("static lane wrong level");
    AST_NAND_PERMIT: assert property (@(posedge clk) disable iff (!rst_n)
        (cfgDone_q[0] && cfg_q[1:0] == 2'h1)
        |=> rearInterlockOutLane[0] == $past(&(srcValid | ~cfg_q[6:3]))) // RULE8
        else $error("nand lane wrong result");
    AST_NAND_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
        (cfgDone_q[0] && cfg_q[1:0] == 2'h1 && cfg_q[6:3] == 4'h0)
        |=> rearInterlockOutLane[0]) // RULE7
        else $error("disabled sources affect lane");
    AST_NAND_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        (cfgDone_q[0] && cfg_q[1:0] == 2'h1 && cfg_q[3] && !srcValid[0])
        |=> !rearInterlockOutLane[0]) // RULE6
        else $error("invalid enabled source not blocking");
    AST_OVERRIDE: assert property (@(posedge clk) disable iff (!rst_n)
        (cfgDone_q[0] && cfg_q[1:0] == 2'h2) |=> rearInterlockOutLane[0] == $past(ovrSync[0]))
        // RULE9
        else $error("override lane not following fpga");
    AST_APB_ERR: assert property (@(posedge clk) disable iff (!rst_n)
        (setup && !mapped) |=> pslverr) // RULE4
        else $error("unmapped access without error");
    COV_NAND: cover property (@(posedge clk) cfg_q[1:0] == 2'h1 && rearInterlockOutLane[0]);
    COV_OVR: cover property (@(posedge clk) cfg_q[1:0] == 2'h2 && rearInterlockOutLane[0]);
    COV_DRV: cover property (@(posedge clk) rearDriverPowerEnable);
endmodule : interlock_forwarding_logic

// >>> tb/interlock_far_end.sv
// far side model: backplane receivers, board fpga and rear module state
`timescale 1ns/10ps
module interlock_far_end (
    input wire logic [3:0] valid,
    input wire logic [3:0] ovr,
    input wire logic [1:0] rstate,
    output logic laneA,
    output logic laneB,
    output logic laneCryoOk,
    output logic fpgaInterlock,
    output logic [3:0] fpgaOverride,
    output logic [1:0] rearState
);
    // levels only, the path has no handshake to honour
    assign laneA = valid[0];
    assign laneB = valid[1];
    assign laneCryoOk = valid[2];
    assign fpgaInterlock = valid[3];
    assign fpgaOverride = ovr;
    assign rearState = rstate;
endmodule : interlock_far_end

// >>> tb/interlock_forwarding_logic_tb_top.sv
// testbench for the interlock forwarding block
`timescale 1ns/10ps
module interlock_forwarding_logic_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, laneA, laneB, laneCryoOk, fpgaInterlock;
    logic [3:0] fpgaOverride, rearInterlockOutLane;
    logic [1:0] rearState;
    logic rearDriverPowerEnable;
    logic [3:0] valid = 4'hF;
    logic [3:0] ovr = 4'h0;
    logic [1:0] rstate = 2'h0;
    logic [31:0] r;
    logic e;
    int n_fail = 0;
    int check_count = 0;
    always #50 clk = ~clk;
    interlock_far_end interlock_far_end_inst (.valid(valid), .ovr(ovr), .rstate(rstate),
        .laneA(laneA), .laneB(laneB), .laneCryoOk(laneCryoOk),
        .fpgaInterlock(fpgaInterlock), .fpgaOverride(fpgaOverride), .rearState(rearState));
    interlock_forwarding_logic interlock_forwarding_logic_inst (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .laneCryoOk(laneCryoOk),
        .laneA(laneA), .laneB(laneB), .fpgaInterlock(fpgaInterlock),
        .fpgaOverride(fpgaOverride), .rearState(rearState),
        .rearInterlockOutLane(rearInterlockOutLane),
        .rearDriverPowerEnable(rearDriverPowerEnable));
    //////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // setup, then access held until pready is seen high at an edge
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc
    // lane outputs pass two sync flops and one output flop
    task automatic outs(input logic [3:0] lanes, input logic drv);
        repeat (4) @(posedge clk);
        chk({rearDriverPowerEnable, rearInterlockOutLane}, {drv, lanes});
    endtask : outs
    task automatic wrap_up;
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        outs(4'h0, 1'b0);
        acc(1'b1, 12'h014, 32'h1);
        rstate <= 2'h2;
        outs(4'h0, 1'b0);
        acc(1'b1, 12'h000, 32'h4);
        acc(1'b1, 12'h004, 32'h0);
        acc(1'b1, 12'h008, 32'h2);
        acc(1'b1, 12'h00C, 32'h79);
        ovr <= 4'h4;
        outs(4'hD, 1'b1);
        valid <= 4'h0;
        ovr <= 4'h0;
        outs(4'h1, 1'b1);
        // each source alone: enabled and failing blocks, disabled is ignored
        for (int k = 0; k < 4; k++) begin
            valid <= ~(4'h1 << k);
            acc(1'b1, 12'h00C, 32'h1 | (32'h8 << k));
            outs(4'h1, 1'b1);
            acc(1'b1, 12'h00C, 32'h1 | (32'h8 << ((k + 1) % 4)));
            outs(4'h9, 1'b1);
        end
        for (int s = 0; s < 4; s++) begin
            rstate <= s[1:0];
            outs(4'h9, s == 2);
        end
        acc(1'b0, 12'h000, 32'h0);
        chk(r, 32'h4);
        acc(1'b1, 12'h010, 32'h7F);
        chk({31'h0, e}, 32'h1);
        acc(1'b0, 12'h010, 32'h0);
        chk(r, 32'h0);
        valid <= 4'h0;
        acc(1'b1, 12'h000, 32'h01);
        outs(4'h1, 1'b0);
        acc(1'b1, 12'h000, 32'h09);
        outs(4'h0, 1'b0);
        ovr <= 4'h1;
        acc(1'b1, 12'h000, 32'h02);
        outs(4'h1, 1'b0);
        acc(1'b0, 12'h018, 32'h0);
        chk(r, 32'h00000CF1);
        wrap_up();
    end
endmodule : interlock_forwarding_logic_tb_top
